// ---- include/spic_pkg.sv ----
// Package for the system clock prescaler and power-mode control block.
// Assumes a single 125 MHz clock domain; shared by core and testbench files.
package spic_pkg;
    localparam int unsigned SPIC_CLK_MHZ = 125;
    // Register offsets on the plain register port
    localparam logic [7:0] SPIC_OFF_PRESCALE = 8'h00;
    localparam logic [7:0] SPIC_OFF_POWER = 8'h01;
    localparam logic [7:0] SPIC_OFF_CONTROL = 8'h02;
    localparam logic [7:0] SPIC_OFF_STATUS = 8'h03;
    // Power-control field positions
    localparam int unsigned SPIC_BIT_SLEEP = 0;
    localparam int unsigned SPIC_BIT_PDOWN = 1;
    localparam int unsigned SPIC_BIT_GF0 = 2;
    localparam int unsigned SPIC_BIT_GF1 = 3;
    localparam int unsigned SPIC_BIT_PON = 4;
    localparam int unsigned SPIC_BIT_LVF = 5;
    localparam int unsigned SPIC_BIT_FESEL = 6;
    localparam int unsigned SPIC_BIT_BAUD2 = 7;
    // Control register field positions
    localparam int unsigned SPIC_BIT_SRC_SEL = 0;
    // Reset values
    localparam logic [2:0] SPIC_PRESCALE_RST = 3'h0;
    localparam logic [7:0] SPIC_POWER_RST = 8'h10;
    localparam logic [7:0] SPIC_CONTROL_RST = 8'h00;
    // Wake-up settle count after power-down, in oscillator clocks
    localparam int unsigned SPIC_WAKE_CLOCKS = 32768;
    localparam int unsigned SPIC_WAKE_W = 16;
    typedef enum logic [1:0]
    {
        SPIC_RUN,
        SPIC_IDLE,
        SPIC_PDOWN,
        SPIC_WAKE
    } spic_mode_t;
endpackage : spic_pkg

// ---- include/spic_div_if.sv ----
// Interface between the control core and the prescale divider.
// Assumes both ends share the one system clock.
`timescale 1ns/1ps
interface spic_div_if;
    logic [2:0] select;
    logic run;
    logic tick;
    modport ctrl
    (
        output select,
        output run,
        input tick
    );
    modport div
    (
        input select,
        input run,
        output tick
    );
endinterface : spic_div_if

// ---- core/spic_divider.sv ----
// Power-of-two prescaler producing a one-cycle enable per divided period.
// Assumes select and run come from flip-flops on the same clock.
`timescale 1ns/1ps
module spic_divider
    import spic_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic src_tick,
    spic_div_if.div dv
);
    logic [6:0] count_reg;
    logic [6:0] count_next;
    logic [2:0] sel_reg;
    logic [2:0] sel_next;
    logic tick_reg;
    logic tick_next;
    logic [6:0] limit;

    // Terminal count for the applied division
    function automatic logic [6:0] spic_limit(input logic [2:0] s);
        spic_limit = 7'((8'h01 << s) - 8'h01);
    endfunction : spic_limit

    always_comb
    begin
        limit = spic_limit(sel_reg);
        count_next = count_reg;
        sel_next = sel_reg;
        tick_next = 1'b0;
        if (dv.run && src_tick)
        begin
            if (count_reg >= limit)
            begin
                count_next = 7'h00;
                tick_next = 1'b1;
                sel_next = dv.select;
            end
            else
            begin
                count_next = 7'(count_reg + 7'h01);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= 7'h00;
            sel_reg <= SPIC_PRESCALE_RST;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            sel_reg <= sel_next;
            tick_reg <= tick_next;
        end
    end

    assign dv.tick = tick_reg;
endmodule : spic_divider

// ---- core/spic_control.sv ----
// System clock prescaler and power-mode control: registers, idle, power-down.
// Assumes the CPU core sits on the far side and honours cpu_clk_en.
// Function
// - Codes 001 to 111 divide the selected source by 2 up to 128.
// - Prescale select resets to 000, passing the source undivided.
// - Crystal or internal RC oscillator feeds the prescaler.
// - Setting the sleep bit enters idle after that instruction completes.
// - Idle stops only the CPU clock; peripherals keep their clock.
// - CPU registers hold their contents during idle.
// - Port pins hold their levels during idle.
// - Address latch and program fetch strobes are driven high in idle.
// - An enabled interrupt clears the sleep bit and ends idle.
// - Interrupt is serviced, then execution resumes after the idle instruction.
// - Power-on flag sets after power cycle; only software clears it.
// - Low-voltage flag sets while supply is below the reference.
// - Two general-purpose read/write flags with no hardware effect.
// - Baud-double bit doubles serial baud in modes 1, 2 and 3.
// - Frame-error select picks mode bit or frame-error flag for bit 7.
// - Power-down bit stops the oscillator after its instruction; state kept.
// - Pin wake from power-down blocks the clock for 32768 oscillator clocks.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module spic_control
    import spic_pkg::*;
#(
    parameter int unsigned WAKE_CLOCKS = SPIC_WAKE_CLOCKS
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic xtal_tick,
    input wire logic rc_tick,
    input wire logic power_on_event,
    input wire logic low_volt_in,
    input wire logic irq_pending,
    input wire logic wake_pin,
    input wire logic instr_done,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic sys_clk_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_enable,
    output logic hold_state,
    output logic strobe_force_high,
    output logic irq_service,
    output logic baud_double,
    output logic frame_err_select
);
    logic rst_meta_reg;
    logic rst_n;
    logic [1:0] pon_sync_reg;
    logic [1:0] lv_sync_reg;
    logic [1:0] wake_sync_reg;
    logic [2:0] prescale_reg;
    logic [2:0] prescale_next;
    logic [7:0] power_reg;
    logic [7:0] power_next;
    logic src_sel_reg;
    logic src_sel_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    spic_mode_t mode_reg;
    spic_mode_t mode_next;
    logic [SPIC_WAKE_W-1:0] wake_cnt_reg;
    logic [SPIC_WAKE_W-1:0] wake_cnt_next;
    logic service_reg;
    logic service_next;
    logic src_tick;
    logic pon_s;
    logic lv_s;
    logic wake_s;
    logic [1:0] pon_sync_next;
    logic [1:0] lv_sync_next;
    logic [1:0] wake_sync_next;
    logic [3:0] reg_sel;
    localparam logic [SPIC_WAKE_W-1:0] WAKE_LAST = SPIC_WAKE_W'(WAKE_CLOCKS - 1);

    // One-hot register select shared by the write and read paths
    function automatic logic [3:0] spic_decode(input logic [7:0] a);
        spic_decode = 4'h0;
        if (a == SPIC_OFF_PRESCALE)
        begin
            spic_decode = 4'h1;
        end
        else if (a == SPIC_OFF_POWER)
        begin
            spic_decode = 4'h2;
        end
        else if (a == SPIC_OFF_CONTROL)
        begin
            spic_decode = 4'h4;
        end
        else if (a == SPIC_OFF_STATUS)
        begin
            spic_decode = 4'h8;
        end
    endfunction : spic_decode

    spic_div_if dvif();

    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Pin-domain inputs pass two flip-flops
    always_comb
    begin
        pon_sync_next = {pon_sync_reg[0], power_on_event};
        lv_sync_next = {lv_sync_reg[0], low_volt_in};
        wake_sync_next = {wake_sync_reg[0], wake_pin};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pon_sync_reg <= 2'h0;
            lv_sync_reg <= 2'h0;
            wake_sync_reg <= 2'h0;
        end
        else
        begin
            pon_sync_reg <= pon_sync_next;
            lv_sync_reg <= lv_sync_next;
            wake_sync_reg <= wake_sync_next;
        end
    end

    assign pon_s = pon_sync_reg[1];
    assign lv_s = lv_sync_reg[1];
    assign wake_s = wake_sync_reg[1];

    assign reg_sel = spic_decode(reg_addr);

    // Oscillator source select
    assign src_tick = src_sel_reg ? rc_tick : xtal_tick;

    assign dvif.select = prescale_reg;
    assign dvif.run = (mode_reg != SPIC_PDOWN) && (mode_reg != SPIC_WAKE);

    spic_divider u_div
    (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_tick),
        .dv(dvif.div)
    );

    always_comb
    begin
        prescale_next = prescale_reg;
        power_next = power_reg;
        src_sel_next = src_sel_reg;
        rdata_next = 8'h00;
        mode_next = mode_reg;
        wake_cnt_next = wake_cnt_reg;
        service_next = 1'b0;
        // Register writes
        if (reg_write)
        begin
            if (reg_sel[0])
            begin
                prescale_next = reg_wdata[2:0];
            end
            else if (reg_sel[1])
            begin
                power_next = reg_wdata;
                power_next[SPIC_BIT_LVF] = power_reg[SPIC_BIT_LVF];
            end
            else if (reg_sel[2])
            begin
                src_sel_next = reg_wdata[SPIC_BIT_SRC_SEL];
            end
        end
        // Hardware sets win over software clears
        if (pon_s)
        begin
            power_next[SPIC_BIT_PON] = 1'b1;
        end
        power_next[SPIC_BIT_LVF] = lv_s;
        // Power-mode sequencing
        case (mode_reg)
            SPIC_RUN:
            begin
                if (instr_done && power_reg[SPIC_BIT_PDOWN])
                begin
                    mode_next = SPIC_PDOWN;
                end
                else if (instr_done && power_reg[SPIC_BIT_SLEEP])
                begin
                    mode_next = SPIC_IDLE;
                end
            end
            SPIC_IDLE:
            begin
                if (irq_pending)
                begin
                    power_next[SPIC_BIT_SLEEP] = 1'b0;
                    mode_next = SPIC_RUN;
                    service_next = 1'b1;
                end
            end
            SPIC_PDOWN:
            begin
                if (wake_s)
                begin
                    wake_cnt_next = '0;
                    mode_next = SPIC_WAKE;
                end
            end
            SPIC_WAKE:
            begin
                if (src_tick)
                begin
                    if (wake_cnt_reg == WAKE_LAST)
                    begin
                        power_next[SPIC_BIT_PDOWN] = 1'b0;
                        mode_next = SPIC_RUN;
                        service_next = 1'b1;
                    end
                    else
                    begin
                        wake_cnt_next = SPIC_WAKE_W'(wake_cnt_reg + 1'b1);
                    end
                end
            end
            default:
            begin
                mode_next = SPIC_RUN;
            end
        endcase
        // Register reads, data one cycle later
        if (reg_read)
        begin
            if (reg_sel[0])
            begin
                rdata_next = {5'h00, prescale_reg};
            end
            else if (reg_sel[1])
            begin
                rdata_next = power_reg;
            end
            else if (reg_sel[2])
            begin
                rdata_next = {7'h00, src_sel_reg};
            end
            else if (reg_sel[3])
            begin
                rdata_next = {6'h00, 2'(mode_reg)};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale_reg <= SPIC_PRESCALE_RST;
            power_reg <= SPIC_POWER_RST;
            src_sel_reg <= SPIC_CONTROL_RST[SPIC_BIT_SRC_SEL];
            rdata_reg <= 8'h00;
            mode_reg <= SPIC_RUN;
            wake_cnt_reg <= '0;
            service_reg <= 1'b0;
        end
        else
        begin
            prescale_reg <= prescale_next;
            power_reg <= power_next;
            src_sel_reg <= src_sel_next;
            rdata_reg <= rdata_next;
            mode_reg <= mode_next;
            wake_cnt_reg <= wake_cnt_next;
            service_reg <= service_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign sys_clk_en = dvif.tick;
    assign cpu_clk_en = dvif.tick && (mode_reg == SPIC_RUN);
    assign periph_clk_en = dvif.tick;
    assign osc_enable = (mode_reg != SPIC_PDOWN);
    assign hold_state = (mode_reg != SPIC_RUN);
    assign strobe_force_high = (mode_reg == SPIC_IDLE);
    assign irq_service = service_reg;
    assign baud_double = power_reg[SPIC_BIT_BAUD2];
    assign frame_err_select = power_reg[SPIC_BIT_FESEL];
endmodule : spic_control

// ---- tb/spic_control_chk.sv ----
// Port checker for the prescaler and power-mode control.
// Assumes it is bound into every spic_control instance.
`timescale 1ns/1ps
module spic_control_chk
    import spic_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic irq_pending,
    input wire logic instr_done,
    input wire logic sys_clk_en,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_enable,
    input wire logic hold_state,
    input wire logic strobe_force_high,
    input wire logic irq_service,
    input wire logic baud_double,
    input wire logic frame_err_select
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_cpu_gated: assert property (cpu_clk_en |-> sys_clk_en)
        else $error("cpu enable without system enable");
    a_periph_runs: assert property (sys_clk_en |-> periph_clk_en)
        else $error("peripheral enable missing");
    a_cpu_held: assert property (hold_state |-> !cpu_clk_en)
        else $error("cpu clocked while held");
    a_strobe_idle: assert property (strobe_force_high |-> hold_state)
        else $error("strobes forced outside idle");
    a_idle_exit: assert property
        (strobe_force_high && irq_pending |-> ##[1:2] !strobe_force_high)
        else $error("idle not ended by interrupt");
    a_service_once: assert property (irq_service |=> !irq_service)
        else $error("service pulse too long");
    a_osc_stop: assert property (!osc_enable |-> hold_state)
        else $error("oscillator off while running");
    a_idle_entry: assert property ($rose(strobe_force_high) |-> $past(instr_done))
        else $error("idle entered without a finished instruction");
    a_baud_write: assert property
        (reg_write && reg_addr == SPIC_OFF_POWER |=>
        {baud_double, frame_err_select} == $past(reg_wdata[7:6]))
        else $error("serial bits not written");
endmodule : spic_control_chk

bind spic_control spic_control_chk chk
(
    .clock(clock),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .irq_pending(irq_pending),
    .instr_done(instr_done),
    .sys_clk_en(sys_clk_en),
    .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en),
    .osc_enable(osc_enable),
    .hold_state(hold_state),
    .strobe_force_high(strobe_force_high),
    .irq_service(irq_service),
    .baud_double(baud_double),
    .frame_err_select(frame_err_select)
);

// ---- tb/spic_cpu_model.sv ----
// Far-side model: oscillators and a CPU finishing one instruction per cpu_clk_en pulse.
// Assumes the oscillators stop while osc_enable is low.
`timescale 1ns/1ps
module spic_cpu_model
(
    input wire logic clock,
    input wire logic cpu_clk_en,
    input wire logic osc_enable,
    output logic xtal_tick,
    output logic rc_tick,
    output logic instr_done
);
    logic [1:0] rc_reg = 2'h0;
    always @(posedge clock)
    begin
        rc_reg <= (rc_reg == 2'h2) ? 2'h0 : rc_reg + 2'h1;
        instr_done <= cpu_clk_en;
    end
    assign xtal_tick = osc_enable;
    assign rc_tick = osc_enable && rc_reg == 2'h0;
endmodule : spic_cpu_model

// ---- tb/spic_control_test.sv ----
// Self-checking bench for the prescaler and power-mode control.
// Assumes the far side is spic_cpu_model and a short wake count.
`timescale 1ns/1ps
module spic_control_test;
    import spic_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic pon = 1'b0;
    logic lv = 1'b0;
    logic irq = 1'b0;
    logic wake = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic sys_en, cpu_en, per_en, osc_en, hold, strobe, svc, baud, fesel;
    logic xtal, rc, done;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n, c, p, seen;
    int per_row [8] = '{1, 2, 4, 8, 16, 32, 64, 128};
    spic_cpu_model cpu (.clock(clock), .cpu_clk_en(cpu_en), .osc_enable(osc_en),
        .xtal_tick(xtal), .rc_tick(rc), .instr_done(done));
    spic_control #(.WAKE_CLOCKS(8)) dut (.clock(clock), .arst_n(arst_n),
        .xtal_tick(xtal), .rc_tick(rc), .power_on_event(pon), .low_volt_in(lv),
        .irq_pending(irq), .wake_pin(wake), .instr_done(done), .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr_en), .reg_read(rd_en), .reg_rdata(rdata),
        .sys_clk_en(sys_en), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
        .osc_enable(osc_en), .hold_state(hold), .strobe_force_high(strobe),
        .irq_service(svc), .baud_double(baud), .frame_err_select(fesel));
    initial
    begin
        forever #4 clock = ~clock;
    end
    task complete_run;
        $display("Checks %0d, errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run;
        end
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task do_reset(input int len);
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (len) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : do_reset
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        chk("register", e, rdata);
    endtask : rd
    task measure(output int k);
        k = 0;
        @(negedge clock);
        while (sys_en !== 1'b1 && k < 400)
        begin
            @(negedge clock);
            k++;
        end
        @(negedge clock);
        k = 1;
        while (sys_en !== 1'b1 && k < 400)
        begin
            @(negedge clock);
            k++;
        end
    endtask : measure
    task count_en(output int kc, output int kp);
        kc = 0;
        kp = 0;
        repeat (20)
        begin
            @(negedge clock);
            kc += cpu_en;
            kp += per_en;
        end
    endtask : count_en
    initial
    begin
        repeat (8) @(posedge clock);
        do_reset(1);
        rd(SPIC_OFF_PRESCALE, 8'h00);
        rd(SPIC_OFF_POWER, SPIC_POWER_RST);
        rd(8'h7f, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(SPIC_OFF_PRESCALE, 8'(i));
            measure(n);
            measure(n);
            chk("period", 8'(per_row[i]), n[7:0]);
        end
        wr(SPIC_OFF_CONTROL, 8'h01);
        wr(SPIC_OFF_PRESCALE, 8'h01);
        measure(n);
        measure(n);
        chk("rc period", 8'h06, n[7:0]);
        wr(SPIC_OFF_CONTROL, 8'h00);
        wr(SPIC_OFF_POWER, 8'hcc);
        @(negedge clock);
        chk("serial bits", 8'h03, {6'h00, baud, fesel});
        wr(SPIC_OFF_POWER, 8'h0d);
        repeat (4) @(negedge clock);
        chk("strobes", 8'h03, {6'h00, strobe, hold});
        rd(SPIC_OFF_STATUS, 8'h01);
        count_en(c, p);
        chk("cpu pulses", 8'h00, c[7:0]);
        chk("periph pulses", 8'h0a, p[7:0]);
        @(posedge clock);
        irq <= 1'b1;
        @(posedge clock);
        irq <= 1'b0;
        seen = 0;
        repeat (3)
        begin
            @(negedge clock);
            seen += svc;
        end
        chk("service", 8'h01, seen[7:0]);
        rd(SPIC_OFF_STATUS, 8'h00);
        rd(SPIC_OFF_POWER, 8'h0c);
        @(posedge clock);
        lv <= 1'b1;
        repeat (5) @(posedge clock);
        rd(SPIC_OFF_POWER, 8'h2c);
        wr(SPIC_OFF_POWER, 8'h0c);
        rd(SPIC_OFF_POWER, 8'h2c);
        @(posedge clock);
        lv <= 1'b0;
        pon <= 1'b1;
        repeat (4) @(posedge clock);
        pon <= 1'b0;
        rd(SPIC_OFF_POWER, 8'h1c);
        wr(SPIC_OFF_POWER, 8'h02);
        repeat (4) @(negedge clock);
        chk("oscillator", 8'h00, {7'h00, osc_en});
        @(posedge clock);
        wake <= 1'b1;
        repeat (4) @(posedge clock);
        wake <= 1'b0;
        seen = 0;
        n = 0;
        for (int k = 1; k <= 100; k++)
        begin
            @(negedge clock);
            seen += svc;
            if (svc === 1'b1)
                n = k;
        end
        chk("wake service", 8'h01, seen[7:0]);
        chk("wake delay", 8'h08, n[7:0]);
        rd(SPIC_OFF_POWER, 8'h00);
        wr(SPIC_OFF_POWER, 8'h01);
        repeat (4) @(negedge clock);
        chk("idle before reset", 8'h03, {6'h00, strobe, hold});
        do_reset(24);
        rd(SPIC_OFF_STATUS, 8'h00);
        chk("idle after reset", 8'h00, {6'h00, strobe, hold});
        rd(SPIC_OFF_POWER, SPIC_POWER_RST);
        complete_run;
    end
endmodule : spic_control_test
